// ---- design/adm_pkg.sv ----
// package for the audio dac mode-control register bank
`default_nettype none
package adm_pkg;
    localparam logic [6:0] IDX_LEFT_ATT = 7'h10;
    localparam logic [6:0] IDX_RIGHT_ATT = 7'h11;
    localparam logic [6:0] IDX_FMT_CTRL = 7'h12;
    localparam logic [6:0] IDX_OUT_CTRL = 7'h13;
    localparam logic [6:0] IDX_MODE_CTRL = 7'h14;
    localparam logic [6:0] IDX_ZERO_EN = 7'h15;
    localparam logic [6:0] IDX_ZERO_FLAGS = 7'h16;
    localparam logic [6:0] IDX_DEV_ID = 7'h17;
    // reset values
    localparam logic [7:0] RST_ATT = 8'hff;
    localparam logic [7:0] RST_FMT_CTRL = 8'h50;
    localparam logic [7:0] RST_OUT_CTRL = 8'h00;
    localparam logic [7:0] RST_MODE_CTRL = 8'h00;
    localparam logic [7:0] RST_ZERO_EN = 8'h01;
    // writable bit masks, reserved bits clear
    localparam logic [7:0] MASK_OUT_CTRL = 8'hf7;
    localparam logic [7:0] MASK_MODE_CTRL = 8'h7f;
    localparam logic [7:0] MASK_ZERO_EN = 8'h07;
    // mute threshold: values at or below this are infinite attenuation
    localparam logic [7:0] ATT_MUTE_MAX = 8'h0e;
    // command word field positions
    localparam int CMD_RW_BIT = 15;
    localparam int CMD_IDX_MSB = 14;
    localparam int CMD_IDX_LSB = 8;
    typedef enum logic [1:0] {
        ADM_EMPH_OFF = 2'b00,
        ADM_EMPH_48K = 2'b01,
        ADM_EMPH_44K1 = 2'b10,
        ADM_EMPH_32K = 2'b11
    } adm_emph_t;
    typedef struct packed {
        logic rw;
        logic [6:0] idx;
        logic [7:0] data;
    } adm_cmd_t;
    typedef struct packed {
        logic [7:0] left_gain_level;
        logic [7:0] right_gain_level;
        logic left_mute;
        logic right_mute;
        logic [2:0] audio_format;
        adm_emph_t emphasis_rate_sel;
        logic emphasis_enable;
        logic soft_mute_en;
        logic phase_invert;
        logic [1:0] gain_step_rate;
        logic conversion_disable;
        logic bypass_stereo_sel;
        logic rolloff_sel;
        logic infinite_zero_mute_en;
        logic soft_reset;
        logic bitstream_mode_en;
        logic filter_bypass;
        logic single_channel_mode;
        logic single_channel_source;
        logic [1:0] oversample_rate_sel;
        logic [1:0] fir_perf_sel;
        logic [1:0] fir_rate_sel;
        logic pcm_zero_out_en;
        logic [1:0] bitstream_zero_out_en;
    } adm_ctrl_t;
endpackage : adm_pkg
`default_nettype wire

// ---- design/adm_regs.sv ----
// mode-control register bank of a stereo audio dac
// Overview of operation
// - words 16..21: top bit 1 reads, 0 writes.
// - registers 22 and 23 are read-only; writes ignored.
// - one 8-bit attenuation field per channel, 0 to -120 dB, 0.5 dB.
// - gain in dB is half of field minus 255, for 15..255.
// - field values 0..14 mute the channel completely.
// - both attenuation fields reset to all ones.
// - one shared load gate bit in register 18 for both channels.
// - new attenuation applies only when load gate is one.
// - gate zero keeps applied levels, ignoring new 16/17 writes.
// - de-emphasis rate: off, 48, 44.1, 32 kHz; resets off.
// - rate code 00 off, 01 48k, 10 44.1k, 11 32k.
// - bitstream mode: rate field selects fir performance.
// - bitstream mode: oversample field selects fir operating rate.
// - soft reset bit in register 20, default normal, all modes.
// - bitstream mode enable bit, default disabled.
// - filter bypass bit, default filter enabled.
// - single_channel_mode bit default stereo; source select default left.
// - roll-off select default sharp, only in plain pcm mode.
// - infinite-zero mute default off; pcm and bypass only.
// - pcm zero-out enable default on; bitstream zero field off.
// - per-channel zero flags in register 22, 1 means zero.
// - 5-bit identifier in register 23.
// - soft mute and de-emphasis enables default off, pcm only.
// - conversion control bit in register 19, default enabled.
`default_nettype none
module adm_regs #(
    // arbitrary identifier value
    parameter logic [4:0] UNIT_ID = 5'h00
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command port from serial control logic
    input wire logic cmd_valid,
    input wire adm_pkg::adm_cmd_t cmd,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic cmd_hit,
    // status from datapath
    input wire logic left_zero_flag,
    input wire logic right_zero_flag,
    // effective controls
    output adm_pkg::adm_ctrl_t ctrl
);
    import adm_pkg::*;

    logic [7:0] left_att_reg;
    logic [7:0] right_att_reg;
    logic [7:0] left_app_reg;
    logic [7:0] right_app_reg;
    logic [7:0] fmt_reg;
    logic [7:0] out_reg;
    logic [7:0] mode_reg;
    logic [7:0] zen_reg;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;
    logic wr_en;
    logic rd_en;
    logic [7:0] rd_next;
    logic pcm_mode;
    logic bs_mode;
    logic byp_mode;

    // writable map is 16..21 only
    assign cmd_hit = cmd_valid && cmd.idx >= IDX_LEFT_ATT
        && cmd.idx <= IDX_DEV_ID;
    assign wr_en = cmd_hit && !cmd.rw
        && cmd.idx <= IDX_ZERO_EN;
    assign rd_en = cmd_hit && cmd.rw;

    // stored attenuation words
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_att_reg <= RST_ATT;
            right_att_reg <= RST_ATT;
        end else if (wr_en) begin
            if (cmd.idx == IDX_LEFT_ATT) begin
                left_att_reg <= cmd.data;
            end
            if (cmd.idx == IDX_RIGHT_ATT) begin
                right_att_reg <= cmd.data;
            end
        end
    end

    // applied attenuation follows stored words only while gate is set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_app_reg <= RST_ATT;
            right_app_reg <= RST_ATT;
        end else if (fmt_reg[7]) begin
            left_app_reg <= left_att_reg;
            right_app_reg <= right_att_reg;
        end
    end // gate low holds

    // control words
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fmt_reg <= RST_FMT_CTRL;
            out_reg <= RST_OUT_CTRL;
            mode_reg <= RST_MODE_CTRL;
            zen_reg <= RST_ZERO_EN;
        end else if (wr_en) begin
            case (cmd.idx)
                IDX_FMT_CTRL: begin
                    fmt_reg <= cmd.data;
                end
                IDX_OUT_CTRL: begin
                    out_reg <= cmd.data & MASK_OUT_CTRL;
                end
                IDX_MODE_CTRL: begin
                    mode_reg <= cmd.data & MASK_MODE_CTRL;
                end
                IDX_ZERO_EN: begin
                    zen_reg <= cmd.data & MASK_ZERO_EN;
                end
                default: begin
                end
            endcase
        end
    end

    // readback mux
    always_comb begin
        case (cmd.idx)
            IDX_LEFT_ATT: rd_next = left_att_reg;
            IDX_RIGHT_ATT: rd_next = right_att_reg;
            IDX_FMT_CTRL: rd_next = fmt_reg;
            IDX_OUT_CTRL: rd_next = out_reg;
            IDX_MODE_CTRL: rd_next = mode_reg;
            IDX_ZERO_EN: rd_next = zen_reg;
            IDX_ZERO_FLAGS: rd_next = {6'h00, right_zero_flag,
                left_zero_flag};
            IDX_DEV_ID: rd_next = {3'h0, UNIT_ID};
            default: rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_en;
            if (rd_en) begin
                rd_data_reg <= rd_next;
            end
        end
    end
    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;

    // operating mode decode
    assign bs_mode = mode_reg[5];
    assign byp_mode = mode_reg[4] && !bs_mode;
    assign pcm_mode = !bs_mode && !byp_mode;

    always_comb begin
        ctrl.left_gain_level = left_app_reg;
        ctrl.right_gain_level = right_app_reg;
        ctrl.left_mute = left_app_reg <= ATT_MUTE_MAX;
        ctrl.right_mute = right_app_reg <= ATT_MUTE_MAX;
        ctrl.audio_format = fmt_reg[6:4];
        ctrl.emphasis_rate_sel = bs_mode ? ADM_EMPH_OFF
            : adm_emph_t'(fmt_reg[3:2]);
        ctrl.emphasis_enable = fmt_reg[1] && pcm_mode;
        ctrl.soft_mute_en = fmt_reg[0] && pcm_mode;
        ctrl.phase_invert = out_reg[7];
        ctrl.gain_step_rate = out_reg[6:5];
        ctrl.conversion_disable = out_reg[4];
        ctrl.bypass_stereo_sel = out_reg[2];
        ctrl.rolloff_sel = out_reg[1] && pcm_mode;
        ctrl.infinite_zero_mute_en = out_reg[0] && !bs_mode;
        ctrl.soft_reset = mode_reg[6];
        ctrl.bitstream_mode_en = bs_mode;
        ctrl.filter_bypass = mode_reg[4];
        ctrl.single_channel_mode = mode_reg[3];
        ctrl.single_channel_source = mode_reg[2];
        ctrl.oversample_rate_sel = bs_mode ? 2'b00 : mode_reg[1:0];
        ctrl.fir_perf_sel = bs_mode ? fmt_reg[3:2] : 2'b00;
        ctrl.fir_rate_sel = bs_mode ? mode_reg[1:0] : 2'b00;
        ctrl.pcm_zero_out_en = zen_reg[0];
        ctrl.bitstream_zero_out_en = zen_reg[2:1];
    end

    // checks

    // writes to read-only words leave all state alone
    a_ro_ignore: assert property (@(posedge clk)
        disable iff (!rst_n)
        cmd_valid && !cmd.rw && cmd.idx >= IDX_ZERO_FLAGS
        |=> $stable(fmt_reg) && $stable(zen_reg)
        && $stable(out_reg) && $stable(mode_reg)
        && $stable(left_att_reg) && $stable(right_att_reg))
        else $error("read-only write changed state");

    // every mapped read is answered next cycle
    a_read_answer: assert property (@(posedge clk)
        disable iff (!rst_n)
        cmd_hit && cmd.rw |=> rd_valid)
        else $error("read not answered");

    // writes give no read answer
    a_write_silent: assert property (@(posedge clk)
        disable iff (!rst_n)
        cmd_valid && !cmd.rw |=> !rd_valid)
        else $error("write produced read data");

    // unmapped indices are never answered
    a_unmapped_quiet: assert property (@(posedge clk)
        disable iff (!rst_n)
        cmd_valid && (cmd.idx < IDX_LEFT_ATT || cmd.idx > IDX_DEV_ID)
        |=> !rd_valid)
        else $error("unmapped index answered");

    // left word stores written data
    a_left_store: assert property (@(posedge clk)
        disable iff (!rst_n)
        cmd_valid && !cmd.rw && cmd.idx == IDX_LEFT_ATT
        |=> left_att_reg == $past(cmd.data))
        else $error("left attenuation not stored");

    // right word stores written data
    a_right_store: assert property (@(posedge clk)
        disable iff (!rst_n)
        cmd_valid && !cmd.rw && cmd.idx == IDX_RIGHT_ATT
        |=> right_att_reg == $past(cmd.data))
        else $error("right attenuation not stored");

    // gain outputs carry the applied levels
    a_gain_pass: assert property (@(posedge clk)
        disable iff (!rst_n)
        ctrl.left_gain_level == left_app_reg
        && ctrl.right_gain_level == right_app_reg)
        else $error("gain level not passed on");

    // gate low freezes applied levels
    a_gate_hold: assert property (@(posedge clk)
        disable iff (!rst_n)
        !fmt_reg[7] |=> $stable(left_app_reg) && $stable(right_app_reg))
        else $error("attenuation moved with gate low");

    // gate high loads both channels from one bit
    a_gate_load: assert property (@(posedge clk)
        disable iff (!rst_n)
        fmt_reg[7] |=> left_app_reg == $past(left_att_reg)
        && right_app_reg == $past(right_att_reg))
        else $error("attenuation not loaded");

    // left mute below the lowest step
    a_mute_low: assert property (@(posedge clk)
        disable iff (!rst_n)
        ctrl.left_mute == (ctrl.left_gain_level < 8'h0f))
        else $error("mute threshold wrong");

    // right mute below the lowest step
    a_mute_right: assert property (@(posedge clk)
        disable iff (!rst_n)
        ctrl.right_mute == (ctrl.right_gain_level < 8'h0f))
        else $error("right mute threshold wrong");

    // reserved bits never hold a one
    a_rsv_zero: assert property (@(posedge clk)
        disable iff (!rst_n)
        out_reg[3] == 1'b0 && mode_reg[7] == 1'b0 && zen_reg[7:3] == 5'h00)
        else $error("reserved bit set");

    // rate field decode outside bitstream mode
    a_emph_map: assert property (@(posedge clk)
        disable iff (!rst_n)
        !mode_reg[5]
        |-> ctrl.emphasis_rate_sel == adm_emph_t'(fmt_reg[3:2]))
        else $error("emphasis rate decode wrong");

    // bitstream mode moves rate field to fir performance
    a_fir_perf: assert property (@(posedge clk)
        disable iff (!rst_n)
        mode_reg[5] |-> ctrl.fir_perf_sel == fmt_reg[3:2]
        && ctrl.emphasis_rate_sel == ADM_EMPH_OFF)
        else $error("fir performance remap wrong");

    // bitstream mode moves oversample field to fir rate
    a_bs_remap: assert property (@(posedge clk)
        disable iff (!rst_n)
        mode_reg[5] |-> ctrl.fir_rate_sel == mode_reg[1:0]
        && !ctrl.rolloff_sel && !ctrl.soft_mute_en)
        else $error("bitstream remap wrong");

    // soft reset follows its bit in every mode
    a_soft_reset: assert property (@(posedge clk)
        disable iff (!rst_n)
        ctrl.soft_reset == mode_reg[6])
        else $error("soft reset bit not passed on");

    // bitstream enable follows its bit
    a_bs_enable: assert property (@(posedge clk)
        disable iff (!rst_n)
        ctrl.bitstream_mode_en == mode_reg[5])
        else $error("bitstream enable wrong");

    // filter bypass follows its bit
    a_bypass_bit: assert property (@(posedge clk)
        disable iff (!rst_n)
        ctrl.filter_bypass == mode_reg[4])
        else $error("filter bypass wrong");

    // single_channel_mode mode and source follow their bits
    a_single_channel_mode_bits: assert property (@(posedge clk)
        disable iff (!rst_n)
        ctrl.single_channel_mode == mode_reg[3]
        && ctrl.single_channel_source == mode_reg[2])
        else $error("single_channel_mode controls wrong");

    // roll-off only acts in plain pcm
    a_rolloff_pcm: assert property (@(posedge clk)
        disable iff (!rst_n)
        ctrl.rolloff_sel |-> !mode_reg[5] && !mode_reg[4])
        else $error("roll-off active outside pcm");

    // infinite-zero mute off in bitstream mode
    a_inz_gate: assert property (@(posedge clk)
        disable iff (!rst_n)
        mode_reg[5] |-> !ctrl.infinite_zero_mute_en)
        else $error("infinite-zero mute in bitstream mode");

    // zero-output enables follow their bits
    a_zero_en: assert property (@(posedge clk)
        disable iff (!rst_n)
        ctrl.pcm_zero_out_en == zen_reg[0]
        && ctrl.bitstream_zero_out_en == zen_reg[2:1])
        else $error("zero-output enables wrong");

    // zero flags read back in place
    a_flag_read: assert property (@(posedge clk)
        disable iff (!rst_n)
        cmd_valid && cmd.rw && cmd.idx == IDX_ZERO_FLAGS
        |=> rd_data == {6'h00, $past(right_zero_flag),
        $past(left_zero_flag)})
        else $error("zero flags misreported");

    // identifier read back in place
    a_id_read: assert property (@(posedge clk)
        disable iff (!rst_n)
        cmd_valid && cmd.rw && cmd.idx == IDX_DEV_ID
        |=> rd_data == {3'h0, UNIT_ID})
        else $error("identifier misreported");

    // soft mute and de-emphasis only in pcm
    a_pcm_only: assert property (@(posedge clk)
        disable iff (!rst_n)
        !pcm_mode |-> !ctrl.soft_mute_en && !ctrl.emphasis_enable)
        else $error("pcm-only control active");

    // conversion control follows its bit in all modes
    a_dac_ctrl: assert property (@(posedge clk)
        disable iff (!rst_n)
        ctrl.conversion_disable == out_reg[4])
        else $error("conversion control wrong");
endmodule : adm_regs
`default_nettype wire

// ---- test/adm_host.sv ----
// host model that sends command words to the register bank
`default_nettype none
module adm_host (
    // clock
    input wire logic clk,
    // command port
    output logic cmd_valid,
    output adm_pkg::adm_cmd_t cmd,
    // answer
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic cmd_hit
);
    timeunit 1ns;
    timeprecision 100ps;
    import adm_pkg::*;
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end
    // one word on a rising edge, then the lines show inverted bits
    task automatic send(input logic rw, input logic [6:0] idx,
                        input logic [7:0] d, output logic hit);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{rw: rw, idx: idx, data: d};
        @(negedge clk);
        hit = cmd_hit;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd <= ~cmd;
    endtask : send
    // write, returns once the applied value has landed
    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        logic h;
        send(1'b0, idx, d, h);
        @(posedge clk);
        @(negedge clk);
    endtask : wr
    // read, answer sampled in the cycle after the word
    task automatic rd(input logic [6:0] idx, output logic hit,
                      output logic v, output logic [7:0] d);
        send(1'b1, idx, 8'h00, hit);
        @(negedge clk);
        v = rd_valid;
        d = rd_data;
    endtask : rd
endmodule : adm_host
`default_nettype wire

// ---- test/adm_regs_test.sv ----
// self-checking bench for the mode-control register bank
`default_nettype none
module adm_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    import adm_pkg::*;
    typedef struct packed {
        logic [6:0] idx;
        logic [7:0] wr;
        logic [7:0] exp;
    } adm_row_t;
    localparam logic [4:0] TEST_ID = 5'h0b; // arbitrary value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic left_zero_flag = 1'b0;
    logic right_zero_flag = 1'b1;
    logic cmd_valid, rd_valid, cmd_hit, hit, vld;
    logic [7:0] rd_data, got;
    adm_cmd_t cmd;
    adm_ctrl_t ctrl;
    int failures = 0;
    int compares = 0;
    adm_emph_t emph [4] = '{ADM_EMPH_OFF, ADM_EMPH_48K, ADM_EMPH_44K1,
                            ADM_EMPH_32K};
    adm_row_t rows [8] = '{'{7'h10, 8'h0e, 8'h0e}, '{7'h11, 8'h0f, 8'h0f},
        '{7'h12, 8'hff, 8'hff}, '{7'h13, 8'hff, 8'hf7},
        '{7'h14, 8'hbf, 8'h3f}, '{7'h15, 8'hff, 8'h07},
        '{7'h16, 8'hff, 8'h02}, '{7'h17, 8'hff, {3'h0, TEST_ID}}};
    logic [7:0] rst_exp [6] = '{8'hff, 8'hff, 8'h50, 8'h00, 8'h00, 8'h01};
    always #10 clk = ~clk;
    adm_regs #(.UNIT_ID(TEST_ID)) adm_regs_i (.clk(clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd(cmd), .rd_valid(rd_valid),
        .rd_data(rd_data), .cmd_hit(cmd_hit),
        .left_zero_flag(left_zero_flag), .right_zero_flag(right_zero_flag),
        .ctrl(ctrl));
    adm_host adm_host_i (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd),
        .rd_valid(rd_valid), .rd_data(rd_data), .cmd_hit(cmd_hit));
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rdchk(input logic [6:0] idx, input logic [7:0] e);
        adm_host_i.rd(idx, hit, vld, got);
        chk("read answer", 8'h03, {6'h00, hit, vld});
        chk("rd_data", e, got);
    endtask : rdchk
    task automatic print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            adm_host_i.wr(rows[i].idx, rows[i].wr);
            rdchk(rows[i].idx,
                rows[i].exp);
        end
        adm_host_i.wr(IDX_MODE_CTRL, 8'h00);
        for (int k = 0; k < 4; k++) begin
            adm_host_i.wr(IDX_FMT_CTRL, 8'h52 | 8'(k << 2));
            chk("emphasis", {6'h00, emph[k]},
                {6'h00, ctrl.emphasis_rate_sel});
        end
        adm_host_i.wr(IDX_MODE_CTRL, 8'h21);
        adm_host_i.wr(IDX_FMT_CTRL, 8'h59);
        chk("bitstream", 8'h25, {2'b00, ctrl.fir_perf_sel, ctrl.fir_rate_sel,
            ctrl.soft_mute_en, ctrl.bitstream_mode_en});
        adm_host_i.wr(IDX_MODE_CTRL, 8'h00);
        adm_host_i.wr(IDX_FMT_CTRL, 8'hd0);
        adm_host_i.wr(IDX_LEFT_ATT, 8'h0f);
        adm_host_i.wr(IDX_RIGHT_ATT, 8'h0e);
        chk("mutes", 8'h01,
            {6'h00, ctrl.left_mute, ctrl.right_mute});
        chk("left gain", 8'h0f, ctrl.left_gain_level);
        adm_host_i.rd(7'h18, hit, vld, got);
        chk("unmapped", 8'h00, {6'h00, hit, vld});
        // second reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rst_exp[i]) begin
            rdchk(7'h10 + 7'(i), rst_exp[i]);
        end
        chk("defaults a", 8'h00, {5'h00, ctrl.soft_reset,
            ctrl.bitstream_mode_en,
            ctrl.filter_bypass});
        chk("defaults b", 8'h01, {3'h0, ctrl.conversion_disable,
            ctrl.single_channel_mode, ctrl.single_channel_source,
            ctrl.emphasis_enable,
            ctrl.pcm_zero_out_en});
        @(posedge clk);
        left_zero_flag <= 1'b1;
        right_zero_flag <= 1'b0;
        rdchk(IDX_ZERO_FLAGS, 8'h01);
        chk("rolloff", 8'h00, {6'h00, ctrl.rolloff_sel,
            ctrl.infinite_zero_mute_en});
        adm_host_i.wr(IDX_LEFT_ATT, 8'h20);
        chk("gate low", 8'hff, ctrl.left_gain_level);
        adm_host_i.wr(IDX_FMT_CTRL, 8'hd0);
        chk("gate high", 8'h20, ctrl.left_gain_level);
        chk("right gain", 8'hff, ctrl.right_gain_level);
        print_verdict();
    end
endmodule : adm_regs_test
`default_nettype wire
